// ==== inc/ttp_pkg.sv ====
/*
  Shared constants for the three-channel timer pin block: register map,
  control field positions, reset values and channel modes.
  Assumes a 32-bit AHB-Lite register bus and a 24-bit count width.
*/
package ttp_pkg;

  localparam int unsigned NUM_CH = 3;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned DATA_W = 32;

  // byte offsets: one window per channel, then the interrupt pair
  localparam logic [5:0] CH_STRIDE = 6'h10;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMP = 4'h4;
  localparam logic [3:0] REG_DUTY = 4'h8;
  localparam logic [3:0] REG_CNT = 4'hc;
  localparam logic [5:0] REG_STS = 6'h30;
  localparam logic [5:0] REG_MSK = 6'h34;

  // control/status fields
  localparam int unsigned CS_EN = 0;
  localparam int unsigned CS_MODE = 1;
  localparam int unsigned CS_EXT = 4;
  localparam int unsigned CS_DIR = 5;
  localparam int unsigned CS_GPO = 6;
  localparam int unsigned CS_PIN = 8;
  localparam int unsigned CS_TOUT = 9;
  localparam int unsigned CS_W = 7;

  localparam logic [CS_W-1:0] CTRL_RST = 7'h00;
  localparam logic [CNT_W-1:0] CMP_RST = 24'hffffff;
  localparam logic [CNT_W-1:0] DUTY_RST = 24'h000000;
  localparam logic [NUM_CH-1:0] STS_RST = 3'h0;
  localparam logic [NUM_CH-1:0] MSK_RST = 3'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [2:0] {
    TTP_GPIO = 3'b000,
    TTP_TIMER = 3'b001,
    TTP_PWM = 3'b010,
    TTP_WDOG = 3'b011,
    TTP_EVENT = 3'b100,
    TTP_MEAS = 3'b101
  } ttp_mode_t;

endpackage

// ==== src/ttp_chan.sv ====
/*
  One timer channel: counter, compare, pulse modulation, width capture
  and the level it would put on its pin.
  Assumes the pin level is already synchronous to clk_sys_in.
*/
`timescale 1ns/1ps
`default_nettype none

module ttp_chan (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic en_in,
  input wire logic [2:0] mode_in,
  input wire logic ext_in,
  input wire logic pin_in,
  input wire logic [ttp_pkg::CNT_W-1:0] cmp_in,
  input wire logic [ttp_pkg::CNT_W-1:0] duty_in,
  output logic [ttp_pkg::CNT_W-1:0] cnt_out,
  output logic [ttp_pkg::CNT_W-1:0] cap_out,
  output logic tout_out,
  output logic evt_out
);

  logic pin_prev_q, pin_prev_d;
  logic [ttp_pkg::CNT_W-1:0] cnt_q, cnt_d, cap_q, cap_d;
  logic tout_q, tout_d, evt_q, evt_d;
  logic rise, fall, tick, term;

  assign rise = pin_in & ~pin_prev_q;
  assign fall = ~pin_in & pin_prev_q;
  assign term = (cnt_q == cmp_in);

  always_comb begin
    pin_prev_d = pin_in;
    cnt_d = cnt_q;
    cap_d = cap_q;
    tout_d = tout_q;
    evt_d = 1'b0;
    // internal clock or pin rising edge
    tick = ext_in ? rise : 1'b1;
    if (!en_in) begin
      cnt_d = '0;
      tout_d = 1'b0;
    end else begin
      unique case (mode_in)
        ttp_pkg::TTP_TIMER, ttp_pkg::TTP_EVENT: begin
          if (tick) begin
            cnt_d = term ? '0 : cnt_q + 1'b1;
            evt_d = term;
            if (term) begin
              tout_d = ~tout_q;
            end
          end
        end
        ttp_pkg::TTP_WDOG: begin
          if (tick) begin
            cnt_d = term ? '0 : cnt_q + 1'b1;
            evt_d = term;
            if (term) begin
              tout_d = 1'b1;
            end
          end
        end
        ttp_pkg::TTP_PWM: begin
          if (tick) begin
            cnt_d = term ? '0 : cnt_q + 1'b1;
            evt_d = term;
          end
          tout_d = (cnt_q < duty_in);
        end
        ttp_pkg::TTP_MEAS: begin
          // width of each high pulse on the pin
          if (fall) begin
            cap_d = cnt_q;
            cnt_d = '0;
            evt_d = 1'b1;
          end else if (pin_in && tick) begin
            cnt_d = cnt_q + 1'b1;
          end
        end
        default: begin
          cnt_d = '0;
          tout_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_prev_q <= 1'b0;
      cnt_q <= '0;
      cap_q <= '0;
      tout_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_prev_d;
      cnt_q <= cnt_d;
      cap_q <= cap_d;
      tout_q <= tout_d;
      evt_q <= evt_d;
    end
  end

  assign cnt_out = cnt_q;
  assign cap_out = cap_q;
  assign tout_out = tout_q;
  assign evt_out = evt_q;

endmodule

`default_nettype wire

// ==== src/ttp_top.sv ====
/*
  Three independent timers with their pins, an AHB-Lite register slave
  and one level interrupt.
  Register map, byte addresses, one 32-bit word per register; fields not
  listed read as zero:
    n*0x10 + 0x0   control/status of channel n, n = 0..2
                   [0]   enable; clearing it zeroes count and output
                   [3:1] mode
                   [4]   count rising pin edges instead of clocks
                   [5]   gpio mode: module drives the pin
                   [6]   gpio mode: level driven
                   [8]   pin level, read only
                   [9]   timer output level, read only
    n*0x10 + 0x4   compare, 24 bits, reset all ones
    n*0x10 + 0x8   duty, 24 bits, reset zero
    n*0x10 + 0xc   count, read only; last high width in measure mode
    0x30           event status, bit n for channel n, cleared by a read
    0x34           event mask, same layout, reset zero
  Modes:
    0 gpio, the reset role: pin direction and level from [5] and [6]
    1 timer, pin output toggles at each terminal count
    2 pulse modulation, pin high while count is below duty
    3 watchdog, pin output set at terminal count until disabled
    4 event count, pin is an input
    5 measure, pin is an input
    6, 7 unused, pin is an input and the count stays zero
  A period is compare + 1 ticks. An event sets its status bit one clock
  later and irq_out rises in that same clock when the bit is unmasked.
  A status event that meets a clearing read in one clock wins.
  Pin outputs and enables are registered; enables and gpio levels follow a
  control write one clock after the register takes it, timer output levels two.
  Assumes pins are synchronous to clk_sys_in and each level stands for at
  least one clock; a single AHB-Lite master with hready_in tied to
  hreadyout_out; whole-word transfers only, so hsize_in is not decoded.
*/
// Implementation choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module ttp_top (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic timer_zero_pin_in,
  output logic timer_zero_pin_out,
  output logic timer_zero_pin_oe_out,
  input wire logic timer_one_pin_in,
  output logic timer_one_pin_out,
  output logic timer_one_pin_oe_out,
  input wire logic timer_two_pin_in,
  output logic timer_two_pin_out,
  output logic timer_two_pin_oe_out,
  output logic irq_out
);

  localparam int unsigned N = ttp_pkg::NUM_CH;
  localparam int unsigned W = ttp_pkg::CNT_W;
  localparam int unsigned CW = ttp_pkg::CS_W;

  // register file
  logic [N-1:0][CW-1:0] ctrl_q, ctrl_d;
  logic [N-1:0][W-1:0] cmp_q, cmp_d;
  logic [N-1:0][W-1:0] duty_q, duty_d;
  logic [N-1:0] sts_q, sts_d;
  logic [N-1:0] msk_q, msk_d;
  logic irq_q, irq_d;

  // bus state
  logic wr_pend_q, wr_pend_d;
  logic [5:0] wr_addr_q, wr_addr_d;
  logic [31:0] rdata_q, rdata_d;
  logic ready_q, ready_d;
  logic resp_q, resp_d;

  // pin drive
  logic [N-1:0] pin_o_q, pin_o_d;
  logic [N-1:0] pin_oe_q, pin_oe_d;

  // channel outputs
  logic [N-1:0] pin_lvl;
  logic [N-1:0][W-1:0] cnt;
  logic [N-1:0][W-1:0] cap;
  logic [N-1:0] tout;
  logic [N-1:0] evt;

  logic acc, acc_rd, in_map, sts_rd;

  assign pin_lvl = {timer_two_pin_in, timer_one_pin_in, timer_zero_pin_in};

  // one channel per pin
  for (genvar i = 0; i < N; i++) begin : g_ch
    ttp_chan u_ch (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .en_in(ctrl_q[i][ttp_pkg::CS_EN]),
      .mode_in(ctrl_q[i][ttp_pkg::CS_MODE +: 3]),
      .ext_in(ctrl_q[i][ttp_pkg::CS_EXT]),
      .pin_in(pin_lvl[i]),
      .cmp_in(cmp_q[i]),
      .duty_in(duty_q[i]),
      .cnt_out(cnt[i]),
      .cap_out(cap[i]),
      .tout_out(tout[i]),
      .evt_out(evt[i])
    );
  end

  // address phase
  assign acc = hsel_in & hready_in & (htrans_in == ttp_pkg::HTRANS_NONSEQ);
  assign in_map = (haddr_in[31:6] == '0);
  assign acc_rd = acc & ~hwrite_in & in_map;
  assign sts_rd = acc_rd & (haddr_in[5:0] == ttp_pkg::REG_STS);

  function automatic logic [31:0] rd_word(
    input logic [5:0] a,
    input logic [N-1:0][CW-1:0] c,
    input logic [N-1:0][W-1:0] cm,
    input logic [N-1:0][W-1:0] du,
    input logic [N-1:0][W-1:0] cn,
    input logic [N-1:0][W-1:0] cp,
    input logic [N-1:0] pl,
    input logic [N-1:0] to,
    input logic [N-1:0] st,
    input logic [N-1:0] mk
  );
    logic [31:0] w;
    logic [1:0] ch;
    w = '0;
    ch = a[5:4];
    if (a == ttp_pkg::REG_STS) begin
      w[N-1:0] = st;
    end else if (a == ttp_pkg::REG_MSK) begin
      w[N-1:0] = mk;
    end else if (32'(ch) < N) begin
      unique case (a[3:0])
        ttp_pkg::REG_CTRL: begin
          w[CW-1:0] = c[ch];
          w[ttp_pkg::CS_PIN] = pl[ch];
          w[ttp_pkg::CS_TOUT] = to[ch];
        end
        ttp_pkg::REG_CMP: w[W-1:0] = cm[ch];
        ttp_pkg::REG_DUTY: w[W-1:0] = du[ch];
        ttp_pkg::REG_CNT: begin
          // measure mode shows the last captured width
          if (c[ch][ttp_pkg::CS_MODE +: 3] == ttp_pkg::TTP_MEAS) begin
            w[W-1:0] = cp[ch];
          end else begin
            w[W-1:0] = cn[ch];
          end
        end
        default: w = '0;
      endcase
    end
    return w;
  endfunction

  // bus slave: zero wait states, always OKAY
  always_comb begin
    wr_pend_d = acc & hwrite_in & in_map;
    wr_addr_d = haddr_in[5:0];
    ready_d = 1'b1;
    resp_d = 1'b0;
    rdata_d = '0;
    if (acc_rd) begin
      rdata_d = rd_word(haddr_in[5:0], ctrl_q, cmp_q, duty_q, cnt, cap,
                        pin_lvl, tout, sts_q, msk_q);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rdata_q <= '0;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      rdata_q <= rdata_d;
      ready_q <= ready_d;
      resp_q <= resp_d;
    end
  end

  // register writes in the data phase
  always_comb begin
    logic [1:0] ch;
    ch = wr_addr_q[5:4];
    ctrl_d = ctrl_q;
    cmp_d = cmp_q;
    duty_d = duty_q;
    msk_d = msk_q;
    if (wr_pend_q) begin
      if (wr_addr_q == ttp_pkg::REG_MSK) begin
        msk_d = hwdata_in[N-1:0];
      end else if (32'(ch) < N) begin
        unique case (wr_addr_q[3:0])
          ttp_pkg::REG_CTRL: ctrl_d[ch] = hwdata_in[CW-1:0];
          ttp_pkg::REG_CMP: cmp_d[ch] = hwdata_in[W-1:0];
          ttp_pkg::REG_DUTY: duty_d[ch] = hwdata_in[W-1:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < N; i++) begin
        ctrl_q[i] <= ttp_pkg::CTRL_RST;
        cmp_q[i] <= ttp_pkg::CMP_RST;
        duty_q[i] <= ttp_pkg::DUTY_RST;
      end
      msk_q <= ttp_pkg::MSK_RST;
    end else begin
      ctrl_q <= ctrl_d;
      cmp_q <= cmp_d;
      duty_q <= duty_d;
      msk_q <= msk_d;
    end
  end

  // sticky events, cleared by a status read; a new event wins
  always_comb begin
    sts_d = sts_q;
    if (sts_rd) begin
      sts_d = '0;
    end
    sts_d = sts_d | evt;
    irq_d = |(sts_d & msk_d);
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sts_q <= ttp_pkg::STS_RST;
      irq_q <= 1'b0;
    end else begin
      sts_q <= sts_d;
      irq_q <= irq_d;
    end
  end

  // pin role from each channel's mode
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pin_o_d[i] = tout[i];
      unique case (ctrl_q[i][ttp_pkg::CS_MODE +: 3])
        ttp_pkg::TTP_GPIO: begin
          pin_oe_d[i] = ctrl_q[i][ttp_pkg::CS_DIR];
          pin_o_d[i] = ctrl_q[i][ttp_pkg::CS_GPO];
        end
        ttp_pkg::TTP_TIMER, ttp_pkg::TTP_PWM, ttp_pkg::TTP_WDOG: begin
          pin_oe_d[i] = 1'b1;
        end
        ttp_pkg::TTP_EVENT, ttp_pkg::TTP_MEAS: begin
          pin_oe_d[i] = 1'b0;
        end
        default: pin_oe_d[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_o_q <= '0;
      pin_oe_q <= '0;
    end else begin
      pin_o_q <= pin_o_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign hrdata_out = rdata_q;
  assign hreadyout_out = ready_q;
  assign hresp_out = resp_q;
  assign irq_out = irq_q;
  assign timer_zero_pin_out = pin_o_q[0];
  assign timer_zero_pin_oe_out = pin_oe_q[0];
  assign timer_one_pin_out = pin_o_q[1];
  assign timer_one_pin_oe_out = pin_oe_q[1];
  assign timer_two_pin_out = pin_o_q[2];
  assign timer_two_pin_oe_out = pin_oe_q[2];

endmodule

`default_nettype wire

// ==== verif/ttp_src.sv ====
/* external pulse source on the three timer pins
   assumes the bench loads a pulse count and hold length */
`timescale 1ns/1ps
`default_nettype none
module ttp_src (
  input wire logic clk_sys_in,
  input wire logic [2:0] oe_in,
  input wire logic [2:0] out_in,
  input wire logic [3:0] hold_in,
  input wire logic [3:0] n_in,
  input wire logic ld_in,
  output logic busy_out,
  output logic [2:0] pin_out
);
  logic lvl_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] left_q = 4'h0;
  // each level held hold_in+1 cycles
  always @(posedge clk_sys_in) begin
    if (ld_in) begin
      left_q <= n_in;
      cnt_q <= 4'h0;
    end else if (left_q != 4'h0) begin
      cnt_q <= (cnt_q == hold_in) ? 4'h0 : cnt_q + 4'h1;
      if (cnt_q == hold_in) begin
        lvl_q <= !lvl_q;
        left_q <= left_q - {3'h0, lvl_q};
      end
    end
  end
  assign busy_out = left_q != 4'h0;
  assign pin_out = (oe_in & out_in) | (~oe_in & {3{lvl_q}});
endmodule
`default_nettype wire

// ==== verif/ttp_sva.sv ====
/* checker of pin roles, bus answer and irq of ttp_top
   assumes a bind from the bench top file */
`timescale 1ns/1ps
`default_nettype none
module ttp_sva (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic timer_zero_pin_out,
  input wire logic timer_one_pin_out,
  input wire logic timer_two_pin_out,
  input wire logic timer_zero_pin_oe_out,
  input wire logic timer_one_pin_oe_out,
  input wire logic timer_two_pin_oe_out,
  input wire logic irq_out
);
  logic aw_q;
  logic [5:0] aa_q;
  logic [6:0] cs_q [3];
  logic [2:0] msk_q, oe, po, inm, outm, gpm, off, dir, val;
  assign oe = {timer_two_pin_oe_out, timer_one_pin_oe_out, timer_zero_pin_oe_out};
  assign po = {timer_two_pin_out, timer_one_pin_out, timer_zero_pin_out};
  // shadow of control and mask writes
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_q <= 1'b0;
      aa_q <= 6'h00;
      cs_q <= '{default: 7'h00};
      msk_q <= 3'h0;
    end else begin
      aw_q <= hsel_in && hready_in && htrans_in == 2'h2 && hwrite_in && haddr_in[31:6] == 26'h0;
      aa_q <= haddr_in[5:0];
      if (aw_q && aa_q[3:0] == 4'h0 && aa_q[5:4] != 2'h3) begin
        cs_q[aa_q[5:4]] <= hwdata_in[6:0];
      end
      if (aw_q && aa_q == 6'h34) begin
        msk_q <= hwdata_in[2:0];
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      inm[i] = cs_q[i][3:1] == 3'h4 || cs_q[i][3:1] == 3'h5;
      outm[i] = cs_q[i][3:1] inside {3'h1, 3'h2, 3'h3};
      gpm[i] = cs_q[i][3:1] == 3'h0;
      off[i] = outm[i] && !cs_q[i][0];
      dir[i] = cs_q[i][5];
      val[i] = cs_q[i][6];
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  rst_idle_a: assert property ($rose(rst_n_in) |-> oe == 3'h0 && !irq_out)
    else $error("pin driven or irq after reset");
  in_modes_a: assert property ((oe & $past(inm)) == 3'h0)
    else $error("input mode drives pin");
  out_modes_a: assert property ((~oe & $past(outm)) == 3'h0)
    else $error("output mode leaves pin");
  gpio_dir_a: assert property (((oe ^ $past(dir)) & $past(gpm)) == 3'h0)
    else $error("gpio direction wrong");
  gpio_val_a: assert property (((po ^ $past(val)) & $past(gpm & dir)) == 3'h0)
    else $error("gpio level wrong");
  idle_low_a: assert property ((po & $past(off, 3) & $past(off, 2) & $past(off)) == 3'h0)
    else $error("disabled timer drives high");
  irq_mask_a: assert property (irq_out |-> msk_q != 3'h0)
    else $error("irq with all masked");
  bus_okay_a: assert property (hreadyout_out && !hresp_out)
    else $error("bus not ready or error");
endmodule
`default_nettype wire

// ==== verif/ttp_top_tb.sv ====
/* bench of ttp_top: register reads, pin roles, events and irq
   assumes checker and source model compiled first */
`timescale 1ns/1ps
`default_nettype none
module ttp_top_tb;
  logic clk = 1'b0, rst_n = 1'b0, hsel, hwrite, hrdy, hresp, irq, rdp, ld, busy;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [2:0] po, oe, pw;
  logic [3:0] hold, npl;
  logic [15:0] rnd;
  logic [31:0] q[$];
  logic [31:0] ra[7] = '{32'h00, 32'h10, 32'h20, 32'h04, 32'h28, 32'h34, 32'h40};
  logic [31:0] re[7] = '{32'h0, 32'h0, 32'h0, 32'hffffff, 32'h0, 32'h0, 32'h0};
  int n_errors = 0, total_checks = 0, c, k;
  always #20 clk = ~clk;
  ttp_top dut (.clk_sys_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .timer_zero_pin_in(pw[0]), .timer_zero_pin_out(po[0]), .timer_zero_pin_oe_out(oe[0]),
    .timer_one_pin_in(pw[1]), .timer_one_pin_out(po[1]), .timer_one_pin_oe_out(oe[1]),
    .timer_two_pin_in(pw[2]), .timer_two_pin_out(po[2]), .timer_two_pin_oe_out(oe[2]),
    .irq_out(irq));
  ttp_src src (.clk_sys_in(clk), .oe_in(oe), .out_in(po), .hold_in(hold), .n_in(npl),
    .ld_in(ld), .busy_out(busy), .pin_out(pw));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic complete_run;
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdy;
    int j;
    j = 0;
    do begin
      @(posedge clk);
      j++;
    end while (hrdy !== 1'b1 && j < 50);
    if (j >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdp <= !w;
    rdy();
    rdp <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulses(input logic [3:0] n);
    npl <= n;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (busy !== 1'b0 && k < 200);
    if (k >= 200) begin
      n_errors++;
      complete_run();
    end
    repeat (8) @(posedge clk);
  endtask
  task automatic wchg;
    logic p;
    p = po[2];
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (po[2] === p && k < 50);
    if (k >= 50) begin
      n_errors++;
      complete_run();
    end
  endtask
  always @(posedge clk) begin
    if (rdp) begin
      chk(hrdata, q.pop_front());
    end
  end
  initial begin
    {hsel, hwrite, rdp, ld} = 4'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hold = 4'h1;
    npl = 4'h0;
    rnd = 16'hd76c;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd(ra[i], re[i]);
    for (int m = 0; m < 6; m++) begin
      xfer(1'b1, 32'h0, 32'(32'h20 | (m << 1)));
      repeat (2) @(posedge clk);
      chk(32'(oe[0]), 32'(m < 4));
    end
    xfer(1'b1, 32'h0, 32'h60);
    repeat (2) @(posedge clk);
    chk(32'(po[0]), 32'h1);
    rd(32'h0, 32'h160);
    xfer(1'b1, 32'h0, 32'h0);
    rnd = lfsr(rnd);
    c = int'(rnd[1:0]) + 1;
    hold <= {2'h0, rnd[3:2]} + 4'h1;
    xfer(1'b1, 32'h34, 32'h2);
    xfer(1'b1, 32'h14, 32'(c));
    xfer(1'b1, 32'h10, 32'h19);
    pulses(4'(c));
    chk(32'(irq), 32'h0);
    pulses(4'h1);
    chk(32'(irq), 32'h1);
    rd(32'h30, 32'h2);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    rnd = lfsr(rnd);
    c = int'(rnd[1:0]) + 1;
    xfer(1'b1, 32'h24, 32'(c));
    xfer(1'b1, 32'h20, 32'h3);
    wchg();
    wchg();
    chk(32'(k), 32'(c + 1));
    xfer(1'b1, 32'h20, 32'h7);
    repeat (12) @(posedge clk);
    chk(32'(po[2]), 32'h1);
    xfer(1'b1, 32'h0, 32'hb);
    pulses(4'h1);
    rd(32'hc, 32'(hold) + 32'h1);
    complete_run();
  end
endmodule
bind ttp_top ttp_sva chk_i (.clk_sys_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .timer_zero_pin_out,
  .timer_one_pin_out, .timer_two_pin_out, .timer_zero_pin_oe_out, .timer_one_pin_oe_out,
  .timer_two_pin_oe_out, .irq_out);
`default_nettype wire
